// ==== logic/eepfe_pkg.sv ====
// Purpose: Shared constants and types of the EEPROM two-wire front end.
// Assumes: One 200 MHz clock; bus lines sampled as plain inputs.
// Notes:   Counts are in bits of a byte, bytes of a page, pages of the array or bytes of the buffer.
package eepfe_pkg;
    // Byte framing
    localparam logic [3:0] EEPFE_BYTE_BITS = 4'h8;
    // Array layout
    localparam int EEPFE_PAGE_BYTES = 8;
    localparam int EEPFE_PAGES_1K = 16;
    localparam int EEPFE_PAGES_2K = 32;
    // Data path buffer
    localparam int EEPFE_FIFO_DEPTH = 4;
    // Input reset values: both bus lines idle high, straps low
    localparam logic [4:0] EEPFE_PIN_RST = 5'h18;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100
    } eepfe_state_type;

    typedef enum logic [1:0] {
        KIND_DEV   = 2'b00,
        KIND_WADDR = 2'b01,
        KIND_DATA  = 2'b10
    } eepfe_kind_type;
endpackage

// ==== logic/eepfe_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter per input bit.
// Assumes: Inputs are asynchronous to i_clk.
// Notes:   A level moves only when stages two and three agree.
`timescale 1ns/1ps
module eepfe_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Raw and filtered levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } eepfe_sync_type;

    eepfe_sync_type st_ff;
    eepfe_sync_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // One-sample spikes never reach the level
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.lvl[i] = st_ff.s2[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_level = st_ff.lvl;
endmodule // eepfe_sync

// ==== logic/eepfe_fifo.sv ====
// Purpose: Small shift FIFO; the head word always sits in slot zero.
// Assumes: Single clock; push and pop may coincide.
// Notes:   Outputs come straight from flip-flops.
`timescale 1ns/1ps
module eepfe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Fill side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // Drain side
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] count;
        logic valid;
        logic ready;
    } eepfe_fifo_type;

    eepfe_fifo_type st_ff;
    eepfe_fifo_type nxt_st;

    always_comb begin
        logic pop;
        logic push;
        logic [CW-1:0] cnt;
        nxt_st = st_ff;
        pop = st_ff.valid && i_rd_ready;
        push = i_wr_valid && st_ff.ready;
        cnt = st_ff.count;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                nxt_st.mem[i] = st_ff.mem[i + 1];
            end
            cnt = cnt - CW'(1);
        end
        if (push) begin
            nxt_st.mem[cnt] = i_wr_data;
            cnt = cnt + CW'(1);
        end
        nxt_st.count = cnt;
        nxt_st.valid = (cnt != '0);
        nxt_st.ready = (cnt != CW'(DEPTH));
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff <= '0;
            st_ff.ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_wr_ready = st_ff.ready;
    assign o_rd_valid = st_ff.valid;
    assign o_rd_data = st_ff.mem[0];
endmodule // eepfe_fifo

// ==== logic/eepfe_top.sv ====
// Purpose: Two-wire slave front end of a small paged serial EEPROM.
// Assumes: SCL, SDA and straps are asynchronous pins; the write-cycle
//          sequencer and array sit outside and talk through ports.
// Notes:   SDA is open drain: o_sda_oe high pulls the line low.
// Contract
// - Sample SDA on SCL rise; change own SDA only after SCL fall.
// - Bytes move most significant bit first.
// - Eight clocks per byte plus a ninth acknowledge clock, no gaps.
// - SDA falling with SCL high is Start; it wakes and begins a command.
// - Watch for Start always; ignore the bus until one is seen.
// - SDA rising with SCL high is Stop; transfer ends, Standby follows.
// - Repeated Start ends the transfer and begins a new command.
// - Bus is idle only while SCL and SDA are both high.
// - No byte limit between Start and Stop.
// - Transmitter releases after eighth fall; receiver holds low ninth high.
// - Receiver releases SDA at the end of the ninth clock.
// - Master high in ninth clock after device byte: release, Standby.
// - Standby after power-up, plain Stop, write-cycle end, address mismatch.
// - Array holds 8-byte pages: 16 or 32 of them.
// - Upper nibble of first byte is compared with the type identifier.
// - Address bits 3..1 match three straps; floating strap reads zero.
// - Address bit 0 high means read, low means write.
// - Acknowledge a matching address byte; not a failing one.
// - Word address byte follows; bit 7 ignored on the small variant.
// - No address acknowledge while an internal write cycle runs.
`timescale 1ns/1ps
module eepfe_top
    import eepfe_pkg::*;
#(
    parameter bit MEM_2KBIT = 1'b1,
    // Device type identifier; value arbitrary
    parameter logic [3:0] TYPE_ID = 4'h5,
    parameter int FIFO_DEPTH = EEPFE_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Address straps
    input wire logic i_strap_addr_hi,
    input wire logic i_strap_addr_mid,
    input wire logic i_strap_addr_lo,
    // Internal write cycle status
    input wire logic i_wr_cycle_busy,
    // Read data for the master
    input wire logic [7:0] i_tx_data,
    output logic o_tx_taken,
    // Received data stream
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    // Transfer status
    output logic o_start,
    output logic o_stop,
    output logic o_rw,
    output logic [7:0] o_word_addr,
    output logic o_word_addr_valid,
    output logic o_host_nack,
    output logic o_standby,
    output logic o_bus_idle
);
    localparam int PAGES = MEM_2KBIT ? EEPFE_PAGES_2K : EEPFE_PAGES_1K;
    localparam int ARRAY_BYTES = EEPFE_PAGE_BYTES * PAGES;
    localparam logic [7:0] WADDR_MASK = 8'(ARRAY_BYTES - 1);

    typedef struct packed {
        eepfe_state_type state;
        eepfe_kind_type kind;
        logic [3:0] cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic rw;
        logic [7:0] waddr;
        logic mnack;
        logic scl_prev;
        logic sda_prev;
        logic sda_oe;
        logic standby;
        logic bus_idle;
        logic start_p;
        logic stop_p;
        logic tx_taken_p;
        logic host_nack_p;
        logic waddr_p;
        logic push;
    } eepfe_core_type;

    eepfe_core_type st_ff;
    eepfe_core_type nxt_st;

    logic [4:0] pins;
    logic scl_q;
    logic sda_q;
    logic [2:0] strap_q;
    logic fifo_wr_ready;

    eepfe_sync #(
        .W(5),
        .RST_VAL(EEPFE_PIN_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_scl, i_sda_in, i_strap_addr_hi, i_strap_addr_mid,
            i_strap_addr_lo}),
        .o_level(pins)
    );

    assign scl_q = pins[4];
    assign sda_q = pins[3];
    assign strap_q = pins[2:0];

    eepfe_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_valid(st_ff.push),
        .i_wr_data(st_ff.rx_sh),
        .o_wr_ready(fifo_wr_ready),
        .o_rd_valid(o_rx_valid),
        .o_rd_data(o_rx_data),
        .i_rd_ready(i_rx_ready)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic ev_ok;
    logic addr_hit;
    logic dev_decide;

    assign scl_rise = scl_q && !st_ff.scl_prev;
    assign scl_fall = !scl_q && st_ff.scl_prev;
    // SCL must stay high across the SDA edge
    assign start_ev = scl_q && st_ff.scl_prev && st_ff.sda_prev
        && !sda_q;
    assign stop_ev = scl_q && st_ff.scl_prev && !st_ff.sda_prev
        && sda_q;
    assign ev_ok = !start_ev && !stop_ev;
    // Straps float low at the pad, so the sampled level already reads 0
    assign addr_hit = (st_ff.rx_sh[7:4] == TYPE_ID)
        && (st_ff.rx_sh[3:1] == strap_q);
    assign dev_decide = st_ff.state == ST_RX && st_ff.kind == KIND_DEV
        && st_ff.cnt == EEPFE_BYTE_BITS && scl_fall && ev_ok;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_prev = scl_q;
        nxt_st.sda_prev = sda_q;
        nxt_st.start_p = 1'b0;
        nxt_st.stop_p = 1'b0;
        nxt_st.tx_taken_p = 1'b0;
        nxt_st.host_nack_p = 1'b0;
        nxt_st.waddr_p = 1'b0;
        nxt_st.push = 1'b0;
        nxt_st.bus_idle = scl_q && sda_q;
        if (start_ev) begin
            // Start wins in every state, so a repeated one restarts
            nxt_st.state = ST_RX;
            nxt_st.kind = KIND_DEV;
            nxt_st.cnt = 4'h0;
            nxt_st.sda_oe = 1'b0;
            nxt_st.start_p = 1'b1;
        end else if (stop_ev) begin
            nxt_st.state = ST_IDLE;
            nxt_st.sda_oe = 1'b0;
            nxt_st.stop_p = 1'b1;
        end else begin
            unique case (st_ff.state)
                ST_IDLE: begin
                    nxt_st.sda_oe = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        nxt_st.rx_sh = {st_ff.rx_sh[6:0], sda_q};
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall && st_ff.cnt == EEPFE_BYTE_BITS)
                    begin
                        unique case (st_ff.kind)
                            KIND_DEV: begin
                                if (addr_hit && !i_wr_cycle_busy) begin
                                    nxt_st.sda_oe = 1'b1;
                                    nxt_st.rw = st_ff.rx_sh[0];
                                    nxt_st.state = ST_RX_ACK;
                                end else begin
                                    nxt_st.state = ST_IDLE;
                                end
                            end
                            KIND_WADDR: begin
                                nxt_st.sda_oe = 1'b1;
                                nxt_st.waddr = st_ff.rx_sh & WADDR_MASK;
                                nxt_st.waddr_p = 1'b1;
                                nxt_st.state = ST_RX_ACK;
                            end
                            KIND_DATA: begin
                                // A full buffer refuses the byte by NACK
                                nxt_st.sda_oe = fifo_wr_ready;
                                nxt_st.push = fifo_wr_ready;
                                nxt_st.state = ST_RX_ACK;
                            end
                            default: begin
                                nxt_st.state = ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.cnt = 4'h0;
                        if (st_ff.kind == KIND_DEV && st_ff.rw) begin
                            nxt_st.tx_sh = i_tx_data;
                            nxt_st.sda_oe = !i_tx_data[7];
                            nxt_st.tx_taken_p = 1'b1;
                            nxt_st.state = ST_TX;
                        end else begin
                            // Data bytes loop with no count limit
                            nxt_st.state = ST_RX;
                            nxt_st.kind = (st_ff.kind == KIND_DEV)
                                ? KIND_WADDR : KIND_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_ff.cnt == EEPFE_BYTE_BITS) begin
                            nxt_st.sda_oe = 1'b0;
                            nxt_st.mnack = 1'b1;
                            nxt_st.state = ST_TX_ACK;
                        end else begin
                            nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b0};
                            nxt_st.sda_oe = !st_ff.tx_sh[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nxt_st.mnack = sda_q;
                    end else if (scl_fall) begin
                        nxt_st.cnt = 4'h0;
                        if (st_ff.mnack) begin
                            nxt_st.state = ST_IDLE;
                            nxt_st.host_nack_p = 1'b1;
                        end else begin
                            nxt_st.tx_sh = i_tx_data;
                            nxt_st.sda_oe = !i_tx_data[7];
                            nxt_st.tx_taken_p = 1'b1;
                            nxt_st.state = ST_TX;
                        end
                    end
                end
                default: begin
                    nxt_st.state = ST_IDLE;
                    nxt_st.sda_oe = 1'b0;
                end
            endcase
        end
        // Standby also holds off until a running write cycle ends
        nxt_st.standby = (nxt_st.state == ST_IDLE)
            && !i_wr_cycle_busy;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff <= '0;
            st_ff.scl_prev <= 1'b1;
            st_ff.sda_prev <= 1'b1;
            st_ff.standby <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe = st_ff.sda_oe;
    assign o_tx_taken = st_ff.tx_taken_p;
    assign o_start = st_ff.start_p;
    assign o_stop = st_ff.stop_p;
    assign o_rw = st_ff.rw;
    assign o_word_addr = st_ff.waddr;
    assign o_word_addr_valid = st_ff.waddr_p;
    assign o_host_nack = st_ff.host_nack_p;
    assign o_standby = st_ff.standby;
    assign o_bus_idle = st_ff.bus_idle;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_ack_driven;
        st_ff.state == ST_RX_ACK && o_sda_oe && scl_rise;
    endsequence

    sequence s_ack_end;
        st_ff.state == ST_RX_ACK && scl_fall && ev_ok
            && !(st_ff.kind == KIND_DEV && st_ff.rw);
    endsequence

    sequence s_master_nack;
        st_ff.state == ST_TX_ACK && st_ff.mnack && scl_fall && ev_ok;
    endsequence

    a_oe_after_fall: assert property (
        $changed(o_sda_oe) |->
            $past(scl_fall) || $past(start_ev) || $past(stop_ev))
        else $error("SDA drive changed without SCL fall");
    a_start_restart: assert property (
        start_ev |=> st_ff.state == ST_RX && st_ff.cnt == 4'h0
            && !o_sda_oe && o_start ##1 !o_start)
        else $error("Start did not begin a new command");
    a_idle_ignore: assert property (
        st_ff.state == ST_IDLE && !start_ev |=>
            st_ff.state == ST_IDLE && !o_sda_oe)
        else $error("Idle state left without Start");
    a_stop_standby: assert property (
        stop_ev && !i_wr_cycle_busy |=> o_stop && o_standby)
        else $error("Stop did not return to standby");
    a_rx_bit_count: assert property (
        st_ff.state == ST_RX && scl_rise && ev_ok |=>
            st_ff.cnt == $past(st_ff.cnt) + 4'h1)
        else $error("Receive bit count slipped");
    a_ack_hold_high: assert property (
        s_ack_driven |=> o_sda_oe [*2])
        else $error("Acknowledge dropped during SCL high");
    a_ack_release: assert property (
        s_ack_end |=> !o_sda_oe && st_ff.state == ST_RX
            && st_ff.cnt == 4'h0)
        else $error("Acknowledge not released after ninth clock");
    a_host_nack_exit: assert property (
        s_master_nack |=> st_ff.state == ST_IDLE && !o_sda_oe
            && o_host_nack)
        else $error("Master NACK did not end the read");
    a_addr_ack: assert property (
        dev_decide && addr_hit && !i_wr_cycle_busy |=>
            o_sda_oe && o_rw == $past(st_ff.rx_sh[0]))
        else $error("Matching address not acknowledged");
    a_addr_miss: assert property (
        dev_decide && !addr_hit |=> !o_sda_oe && st_ff.state == ST_IDLE)
        else $error("Mismatched address acknowledged");
    a_busy_nack: assert property (
        dev_decide && i_wr_cycle_busy |=> !o_sda_oe)
        else $error("Address acknowledged during write cycle");
    a_msb_first: assert property (
        st_ff.state == ST_RX_ACK && scl_fall && ev_ok
            && st_ff.kind == KIND_DEV && st_ff.rw |=>
            o_sda_oe == !$past(i_tx_data[7]) && o_tx_taken)
        else $error("Read byte did not start with its top bit");
endmodule // eepfe_top

// ==== sim/eepfe_master.sv ====
// Purpose: Bus master model driving SCL and its own side of SDA.
// Assumes: SDA has a pull-up; the wire level comes back on i_sda.
// Notes:   Lines move on i_clk falls; SCL rests high between frames.
`timescale 1ns/1ps
module eepfe_master (
    // Clock
    input wire logic i_clk,
    // Wire level of SDA
    input wire logic i_sda,
    // Driven lines
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Quarter period of 8 clocks gives a 160 ns SCL
    task automatic bit_io(input logic b, output logic s);
        o_scl = 1'b0;
        w(8);
        o_sda = b;
        w(8);
        o_scl = 1'b1;
        w(8);
        s = i_sda;
        w(8);
    endtask

    task automatic start_c();
        logic s;
        bit_io(1'b1, s);
        o_sda = 1'b0;
        w(16);
    endtask

    task automatic stop_c();
        logic s;
        bit_io(1'b0, s);
        o_sda = 1'b1;
        w(16);
    endtask

    // Ninth clock released so the receiver can answer
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, s);
    endtask

    // Dummy clocks until the device lets SDA go, nine at most
    task automatic recover(output int n);
        logic s;
        n = 0;
        do begin
            bit_io(1'b1, s);
            n++;
        end while (s !== 1'b1 && n < 9);
    endtask
endmodule // eepfe_master

// ==== sim/tb.sv ====
// Purpose: Self-checking bench of the EEPROM two-wire front end.
// Assumes: Master model owns SCL; SDA is a wired AND with pull-up.
// Notes:   Read data come from a small table stepped on o_tx_taken.
`timescale 1ns/1ps
module tb;
    // Arbitrary type code, matches the design parameter
    localparam logic [3:0] TID = 4'h5;
    logic clk, rst, scl, m_sda, sda, oe, sda_out, busy, rx_ready;
    logic s_hi, s_mid, s_lo, tx_taken, rx_valid, st, sp, rw;
    logic wav, hnack, stby, idle, oe2;
    logic [7:0] tx_data, rx_data, waddr, waddr2;
    logic [7:0] tx_tbl [4] = '{8'h96, 8'h4B, 8'h00, 8'hFF};
    int fail_count, n_checks, n_start, n_nack, tx_i, n_stop, n_wav;

    // Device data value only counts while it drives the line
    assign sda = m_sda & (~oe | sda_out) & ~oe2;
    assign tx_data = tx_tbl[tx_i];

    eepfe_top #(.TYPE_ID(TID)) i_dut (.i_clk(clk), .i_sys_rst(rst),
        .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
        .i_strap_addr_hi(s_hi), .i_strap_addr_mid(s_mid),
        .i_strap_addr_lo(s_lo), .i_wr_cycle_busy(busy),
        .i_tx_data(tx_data), .o_tx_taken(tx_taken), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data), .i_rx_ready(rx_ready), .o_start(st),
        .o_stop(sp), .o_rw(rw), .o_word_addr(waddr),
        .o_word_addr_valid(wav), .o_host_nack(hnack), .o_standby(stby),
        .o_bus_idle(idle));
    eepfe_master i_master (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda(m_sda));
    // Small array on the same bus; inverted straps keep it apart
    eepfe_top #(.TYPE_ID(TID), .MEM_2KBIT(1'b0)) i_dut_small (.i_clk(clk),
        .i_sys_rst(rst), .i_scl(scl), .i_sda_in(sda), .o_sda_out(),
        .o_sda_oe(oe2), .i_strap_addr_hi(~s_hi), .i_strap_addr_mid(~s_mid),
        .i_strap_addr_lo(~s_lo), .i_wr_cycle_busy(1'b0), .i_tx_data(8'h00),
        .o_tx_taken(), .o_rx_valid(), .o_rx_data(), .i_rx_ready(1'b0),
        .o_start(), .o_stop(), .o_rw(), .o_word_addr(waddr2),
        .o_word_addr_valid(), .o_host_nack(), .o_standby(), .o_bus_idle());

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Pulses counted on the falling edge, away from the launching edge
    always @(negedge clk) begin
        n_start += int'(st === 1'b1);
        n_stop += int'(sp === 1'b1);
        n_wav += int'(wav === 1'b1);
        n_nack += int'(hnack === 1'b1);
    end

    // Next read byte is offered once the previous one is taken
    always @(negedge clk) begin
        if (tx_taken === 1'b1) begin
            tx_i++;
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chkb(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic t_no_start();
        logic a;
        i_master.put_byte({TID, 4'hA}, a);
        chkb(a, 1'b0);
        chkb(stby, 1'b1);
    endtask

    // Fifth byte finds the buffer full and is refused
    task automatic t_write();
        logic a;
        logic [7:0] d [5] = '{8'h3C, 8'hC3, 8'h01, 8'h80, 8'h7E};
        i_master.start_c();
        chkb(stby, 1'b0);
        chkb(idle, 1'b0);
        i_master.put_byte({TID, 4'hA}, a);
        chkb(a, 1'b1);
        chkb(rw, 1'b0);
        i_master.put_byte(8'hA5, a);
        chkb(a, 1'b1);
        chk(waddr, 8'hA5);
        for (int i = 0; i < 5; i++) begin
            i_master.put_byte(d[i], a);
            chkb(a, i < 4);
        end
        i_master.stop_c();
        chkb(stby, 1'b1);
        chkb(idle, 1'b1);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 20 && rx_valid !== 1'b1; k++)
                @(negedge clk);
            chkb(rx_valid, 1'b1);
            if (rx_valid !== 1'b1) wrap_up();
            chk(rx_data, d[i]);
            rx_ready = 1'b1;
            @(negedge clk);
            rx_ready = 1'b0;
        end
        chkb(rx_valid, 1'b0);
    endtask

    // Polling while the write cycle runs, then a repeated Start
    task automatic t_busy();
        logic a;
        busy = 1'b1;
        i_master.start_c();
        i_master.put_byte({TID, 4'hA}, a);
        chkb(a, 1'b0);
        busy = 1'b0;
        i_master.start_c();
        i_master.put_byte({TID, 4'hA}, a);
        chkb(a, 1'b1);
        i_master.stop_c();
    endtask

    task automatic t_mismatch();
        logic a;
        logic [7:0] bad [4] = '{{TID ^ 4'h8, 4'hA}, {TID, 4'h2},
            {TID, 4'hE}, {TID, 4'h8}};
        foreach (bad[i]) begin
            i_master.start_c();
            i_master.put_byte(bad[i], a);
            chkb(a, 1'b0);
            chkb(stby, 1'b1);
            i_master.stop_c();
        end
    endtask

    // Random read on the strapless address
    task automatic t_read();
        logic a;
        logic [7:0] b;
        {s_hi, s_mid, s_lo} = 3'h0;
        i_master.start_c();
        i_master.put_byte({TID, 4'h0}, a);
        chkb(a, 1'b1);
        i_master.put_byte(8'h7F, a);
        chk(waddr, 8'h7F);
        i_master.start_c();
        i_master.put_byte({TID, 4'h1}, a);
        chkb(a, 1'b1);
        chkb(rw, 1'b1);
        i_master.get_byte(1'b1, b);
        chk(b, 8'h96);
        i_master.get_byte(1'b0, b);
        chk(b, 8'h4B);
        chkb(oe, 1'b0);
        // NACK takes effect at the ninth fall, inside the Stop clock
        i_master.stop_c();
        chk(8'(n_nack), 8'h1);
        chk(8'(tx_i), 8'h2);
        chkb(stby, 1'b1);
    endtask

    // Read abandoned after three bits, bus freed by dummy clocks
    task automatic t_broken();
        logic a;
        int n;
        i_master.start_c();
        i_master.put_byte({TID, 4'h1}, a);
        chkb(a, 1'b1);
        repeat (3) i_master.bit_io(1'b1, a);
        i_master.recover(n);
        chk(8'(n), 8'h6);
        chkb(sda, 1'b1);
        i_master.start_c();
        i_master.put_byte({TID, 4'h0}, a);
        chkb(a, 1'b1);
        i_master.stop_c();
        chk(8'(n_nack), 8'h2);
        chk(8'(n_start), 8'h0B);
        chk(8'(n_stop), 8'h08);
        chk(8'(n_wav), 8'h02);
    endtask

    // Small array drops bit 7 of the word address
    task automatic t_small();
        logic a;
        i_master.start_c();
        i_master.put_byte({TID, 4'hE}, a);
        chkb(a, 1'b1);
        i_master.put_byte(8'hFF, a);
        chkb(a, 1'b1);
        chk(waddr2, 8'h7F);
        i_master.stop_c();
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        busy = 1'b0;
        rx_ready = 1'b0;
        {s_hi, s_mid, s_lo} = 3'h5;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        t_no_start();
        t_write();
        t_busy();
        t_mismatch();
        t_read();
        t_broken();
        t_small();
        wrap_up();
    end
endmodule // tb
